// ==== hw/serial_ctl_map.svh ====
// constants of the serial control port and the power control register
// assumes: included by bare name from the package and the design modules
`ifndef SERIAL_CTL_MAP_SVH
`define SERIAL_CTL_MAP_SVH

// frame layout
`define CORE_ADDR_BITS 10
`define WMM_ADDR_BITS 7
`define FRAME_DATA_MAX 16
`define FRAME_BITS_MAX 27
`define FRAME_CNT_W 5
`define FRAME_CNT_MAX 5'h1f
`define DIR_READ 1'b0
`define DIR_WRITE 1'b1

// power control register
`define PWR_CTRL_ADDR 10'h1c3
`define PWR_CTRL_W 13
`define PWR_CTRL_RESET 13'h1fc0
`define PWR_LOW_REG_BIT 0
`define PWR_CLK_REG_BIT 1
`define PWR_CONV_REG_BIT 2
`define PWR_BGAP_REG_BIT 3
`define PWR_COMMON_BIT 4
`define PWR_OUTCLK_BIT 5
`define PWR_LOOPCLK_BIT 6
`define PWR_TEST_B_BIT 7
`define PWR_TEST_A_BIT 8
`define PWR_IN_B_BIT 9
`define PWR_IN_A_BIT 10
`define PWR_CONV_B_BIT 11
`define PWR_CONV_A_BIT 12

// timing
`define REF_CLK_PERIOD_NS 4
`define SCLK_HALF_NS 16
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define SCLK_CNT_W 4
`define POST_FRAME_CLKS 3

// host command registers (word index on the plain port)
`define HOST_REG_AW 4
`define HOST_ADDR_REG 4'h0
`define HOST_WDATA_REG 4'h1
`define HOST_LEN_REG 4'h2
`define HOST_CTRL_REG 4'h3
`define HOST_STATUS_REG 4'h4
`define HOST_RDATA_REG 4'h5
`define HOST_WIDE_BIT 16
`define CTRL_START_BIT 0
`define CTRL_WRITE_BIT 1
`define STATUS_BUSY_BIT 0
`define STATUS_DONE_BIT 1

`endif

// ==== hw/serial_ctl_pkg.sv ====
// types shared by both ends of the serial control port
// assumes: serial_ctl_map.svh on the include path
`include "serial_ctl_map.svh"

package serial_ctl_pkg;
  typedef enum {DEV_IDLE, DEV_ADDR, DEV_DIR, DEV_DATA} dev_state_e;
  typedef enum {HOST_IDLE, HOST_SHIFT, HOST_FLUSH} host_state_e;
  typedef logic [`PWR_CTRL_W-1:0] pwr_word_t;
  typedef logic [`FRAME_BITS_MAX-1:0] frame_t;
  typedef logic [`FRAME_CNT_W-1:0] frame_cnt_t;
endpackage

// ==== hw/serial_link_if.sv ====
// four-wire serial control link between host and device
// assumes: both ends run on the same ref_clk; every wire is one-way
`timescale 1ns/1ps

interface serial_link_if;
  logic frame_en;
  logic shift_clk;
  logic to_device;
  logic from_device;

  modport host_end (
    output frame_en,
    output shift_clk,
    output to_device,
    input from_device
  );

  modport device_end (
    input frame_en,
    input shift_clk,
    input to_device,
    output from_device
  );
endinterface

// ==== hw/shift_clk_divider.sv ====
// divides ref_clk into the serial shift clock, with edge pulses
// assumes: run is held for whole frames; clock parks low when idle
`timescale 1ns/1ps
`include "serial_ctl_map.svh"

module shift_clk_divider
  import serial_ctl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  // divided clock and its edges
  output logic shift_clk,
  output logic rise_pulse,
  output logic fall_pulse
);

  logic [`SCLK_CNT_W-1:0] cnt_reg;
  logic wrap;

  assign wrap = (cnt_reg == `SCLK_CNT_W'(`SCLK_HALF_CYC - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !run)
      cnt_reg <= '0;
    else if (wrap)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + `SCLK_CNT_W'(1);
  end

  // pulses mark the cycle in which shift_clk changes
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      shift_clk <= 1'b0;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end
    else if (!run)
    begin
      shift_clk <= 1'b0;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end
    else
    begin
      if (wrap)
        shift_clk <= ~shift_clk;
      rise_pulse <= wrap && !shift_clk;
      fall_pulse <= wrap && shift_clk;
    end
  end

endmodule

// ==== hw/serial_ctl_host.sv ====
// host end: frames register reads and writes on the serial link
// assumes: software drives the plain register port; device on the link
`timescale 1ns/1ps
`include "serial_ctl_map.svh"

module serial_ctl_host
  import serial_ctl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // software register port
  input wire logic [`HOST_REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // serial link
  serial_link_if.host_end link
);

  host_state_e state_reg;
  logic [`CORE_ADDR_BITS-1:0] addr_reg;
  logic wide_reg;
  logic [`FRAME_DATA_MAX-1:0] wdata_reg;
  logic [`FRAME_CNT_W-1:0] len_reg;
  logic [`FRAME_DATA_MAX-1:0] rdata_reg;
  logic done_reg;
  logic en_reg;
  logic sdi_reg;
  frame_t frame_reg;
  frame_cnt_t left_reg;
  frame_cnt_t sent_reg;
  frame_cnt_t hdr_len;
  logic [1:0] flush_reg;
  logic run;
  logic rise;
  logic fall;
  logic start;

  // header (address then direction) and data, both left aligned
  function automatic frame_t compose(
    input logic [`CORE_ADDR_BITS-1:0] addr, input logic wide,
    input logic wr, input logic [`FRAME_DATA_MAX-1:0] data,
    input frame_cnt_t dlen);
    frame_t hdr;
    frame_t dat;
    hdr = wide
          ? frame_t'({addr, wr}) << (`FRAME_BITS_MAX - `CORE_ADDR_BITS - 1)
          : frame_t'({addr[`WMM_ADDR_BITS-1:0], wr})
            << (`FRAME_BITS_MAX - `WMM_ADDR_BITS - 1);
    dat = frame_t'(data) << (`FRAME_BITS_MAX - dlen);
    compose = hdr | (dat >> (wide ? `CORE_ADDR_BITS + 1 : `WMM_ADDR_BITS + 1));
  endfunction

  assign hdr_len = wide_reg ? frame_cnt_t'(`CORE_ADDR_BITS + 1)
                            : frame_cnt_t'(`WMM_ADDR_BITS + 1);
  assign start = reg_wr && reg_addr == `HOST_CTRL_REG
                 && reg_wdata[`CTRL_START_BIT] && state_reg == HOST_IDLE;
  assign run = (state_reg != HOST_IDLE);
  assign link.frame_en = en_reg;
  assign link.to_device = sdi_reg;

  shift_clk_divider u_div (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(run),
    .shift_clk(link.shift_clk),
    .rise_pulse(rise),
    .fall_pulse(fall)
  );

  // command registers are frozen while a frame runs
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      addr_reg <= '0;
      wide_reg <= 1'b1;
      wdata_reg <= '0;
      len_reg <= frame_cnt_t'(`PWR_CTRL_W);
    end
    else if (reg_wr && state_reg == HOST_IDLE)
    begin
      case (reg_addr)
        `HOST_ADDR_REG:
        begin
          addr_reg <= reg_wdata[`CORE_ADDR_BITS-1:0];
          wide_reg <= reg_wdata[`HOST_WIDE_BIT];
        end
        `HOST_WDATA_REG: wdata_reg <= reg_wdata[`FRAME_DATA_MAX-1:0];
        `HOST_LEN_REG: len_reg <= reg_wdata[`FRAME_CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // host changes en and data only after a falling edge [R8] [R14]
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= HOST_IDLE;
      en_reg <= 1'b0;
      sdi_reg <= 1'b0;
      frame_reg <= '0;
      left_reg <= '0;
      sent_reg <= '0;
      flush_reg <= '0;
    end
    else
    begin
      case (state_reg)
        HOST_IDLE:
          if (start)
          begin
            // short data is padded with zeros at the msb end [R12] [R13]
            frame_reg <= compose(addr_reg, wide_reg,
                                 reg_wdata[`CTRL_WRITE_BIT], wdata_reg,
                                 len_reg);
            left_reg <= hdr_len + len_reg;
            sent_reg <= '0;
            state_reg <= HOST_SHIFT;
          end
        HOST_SHIFT:
          if (fall)
          begin
            if (left_reg != '0)
            begin
              en_reg <= 1'b1;
              sdi_reg <= frame_reg[`FRAME_BITS_MAX-1]; // [R9] [R11]
              frame_reg <= frame_reg << 1;
              left_reg <= left_reg - frame_cnt_t'(1);
              sent_reg <= sent_reg + frame_cnt_t'(1);
            end
            else
            begin
              en_reg <= 1'b0;
              sdi_reg <= 1'b0;
              flush_reg <= '0;
              state_reg <= HOST_FLUSH;
            end
          end
        HOST_FLUSH:
          // three whole clock periods after the frame ends [R19]; stopping
          // on a fall keeps the last high phase full length
          if (fall)
          begin
            if (flush_reg == 2'(`POST_FRAME_CLKS - 1))
              state_reg <= HOST_IDLE;
            flush_reg <= flush_reg + 2'(1);
          end
        default: state_reg <= HOST_IDLE;
      endcase
    end
  end

  // device output sampled on rising edges of the data phase
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rdata_reg <= '0;
    else if (start)
      rdata_reg <= '0;
    else if (rise && en_reg && sent_reg > hdr_len)
      rdata_reg <= {rdata_reg[`FRAME_DATA_MAX-2:0], link.from_device};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      done_reg <= 1'b0;
    else if (state_reg == HOST_FLUSH && fall
             && flush_reg == 2'(`POST_FRAME_CLKS - 1))
      done_reg <= 1'b1;
    else if (start)
      done_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `HOST_ADDR_REG:
          reg_rdata <= (32'(wide_reg) << `HOST_WIDE_BIT) | 32'(addr_reg);
        `HOST_WDATA_REG: reg_rdata <= 32'(wdata_reg);
        `HOST_LEN_REG: reg_rdata <= 32'(len_reg);
        `HOST_STATUS_REG:
          reg_rdata <= (32'(done_reg) << `STATUS_DONE_BIT)
                       | (32'(run) << `STATUS_BUSY_BIT);
        `HOST_RDATA_REG: reg_rdata <= 32'(rdata_reg);
        default: reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

endmodule

// ==== hw/serial_ctl_device.sv ====
// device end: serial register port holding the block power control
// assumes: link pins synchronous to ref_clk; shift clock well below it
//
// Operation
// R1: reset returns registers to defaults
// R2: bits 0-3 switch off the four regulators
// R3: bit 4 common circuits, bit 5 out clocks
// R4: bit 6 loop clocks, 7-8 block test out
// R5: bits 9-10 power down channel data inputs
// R6: bits 11-12 power down converter channels
// R7: host keeps channel bits matching converter config
// R8: enable raised at fall, frame starts next rise
// R9: address shifted first, msb first, 7/10 bits; device always takes 10
// R10: input sampled on each rise within frame
// R11: direction bit after address: 0 read, 1 write
// R12: write data msb first, lsb last
// R13: host zero-pads longer fixed-length packets
// R14: enable lowered at fall ends the frame
// R15: old contents shift out during write
// R16: read data out msb first at falls
// R17: zeros follow once register is exhausted
// R18: register reads back at its own width
// R19: host gives three clocks after frame end
// R20: commit only complete data, early end aborts
`timescale 1ns/1ps
`include "serial_ctl_map.svh"

module serial_ctl_device
  import serial_ctl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // serial link
  serial_link_if.device_end link,
  // regulator controls, high means off
  output logic low_voltage_regulator_off,
  output logic clock_regulator_off,
  output logic converter_regulator_off,
  output logic bandgap_regulator_off,
  // shared circuits, high means off
  output logic common_circuits_off,
  output logic output_clocks_off,
  output logic loop_clocks_off,
  // test output access, high means blocked
  output logic test_out_b_blocked,
  output logic test_out_a_blocked,
  // channel controls, high means off
  output logic input_b_off,
  output logic input_a_off,
  output logic converter_b_off,
  output logic converter_a_off
);

  dev_state_e state_reg;
  logic sclk_reg;
  logic sclk_prev_reg;
  logic en_reg;
  logic sdi_reg;
  logic rise;
  logic fall;
  logic [`CORE_ADDR_BITS-1:0] addr_reg;
  frame_cnt_t addr_cnt_reg;
  frame_cnt_t data_cnt_reg;
  logic write_reg;
  logic hit_reg;
  pwr_word_t data_reg;
  pwr_word_t out_reg;
  pwr_word_t pwr_reg;
  logic sdo_reg;
  logic commit;

  // only one register lives here; any other address reads as zeros
  function automatic logic is_power_ctrl(
    input logic [`CORE_ADDR_BITS-1:0] addr);
    is_power_ctrl = (addr == `PWR_CTRL_ADDR);
  endfunction

  // pins are taken once into flops so edges are seen on clean copies
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sclk_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      en_reg <= 1'b0;
      sdi_reg <= 1'b0;
    end
    else
    begin
      sclk_reg <= link.shift_clk;
      sclk_prev_reg <= sclk_reg;
      en_reg <= link.frame_en;
      sdi_reg <= link.to_device;
    end
  end

  assign rise = sclk_reg && !sclk_prev_reg;
  assign fall = !sclk_reg && sclk_prev_reg;

  // a frame ends on the first rise that sees the enable low
  assign commit = rise && !en_reg && state_reg == DEV_DATA
                  && write_reg && hit_reg
                  && data_cnt_reg >= frame_cnt_t'(`PWR_CTRL_W); // [R20]

  // frame sequencing
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      state_reg <= DEV_IDLE;
    else if (rise)
    begin
      case (state_reg)
        DEV_IDLE:
          if (en_reg)
            state_reg <= DEV_ADDR; // [R8]
        DEV_ADDR:
          if (!en_reg)
            state_reg <= DEV_IDLE; // [R14]
          else if (addr_cnt_reg == frame_cnt_t'(`CORE_ADDR_BITS - 1))
            state_reg <= DEV_DIR;
        DEV_DIR:
          if (!en_reg)
            state_reg <= DEV_IDLE;
          else
            state_reg <= DEV_DATA;
        DEV_DATA:
          if (!en_reg)
            state_reg <= DEV_IDLE; // [R14]
        default: state_reg <= DEV_IDLE;
      endcase
    end
  end

  // address collected msb first, first bit taken with the start [R9]
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      addr_reg <= '0;
      addr_cnt_reg <= '0;
    end
    else if (rise && en_reg)
    begin
      if (state_reg == DEV_IDLE)
      begin
        addr_reg <= {{(`CORE_ADDR_BITS-1){1'b0}}, sdi_reg}; // [R10]
        addr_cnt_reg <= frame_cnt_t'(1);
      end
      else if (state_reg == DEV_ADDR)
      begin
        addr_reg <= {addr_reg[`CORE_ADDR_BITS-2:0], sdi_reg}; // [R10]
        addr_cnt_reg <= addr_cnt_reg + frame_cnt_t'(1);
      end
    end
  end

  // direction bit and register selection
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      write_reg <= 1'b0;
      hit_reg <= 1'b0;
    end
    else if (rise && en_reg && state_reg == DEV_DIR)
    begin
      write_reg <= (sdi_reg == `DIR_WRITE); // [R11]
      hit_reg <= is_power_ctrl(addr_reg);
    end
  end

  // write data: the last register-width bits received are kept, so
  // leading padding falls off the top and the value stays right aligned
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      data_reg <= '0;
      data_cnt_reg <= '0;
    end
    else if (rise && en_reg)
    begin
      if (state_reg == DEV_DIR)
      begin
        data_reg <= '0;
        data_cnt_reg <= '0;
      end
      else if (state_reg == DEV_DATA)
      begin
        data_reg <= {data_reg[`PWR_CTRL_W-2:0], sdi_reg}; // [R12] [R10]
        if (data_cnt_reg != `FRAME_CNT_MAX)
          data_cnt_reg <= data_cnt_reg + frame_cnt_t'(1);
      end
    end
  end

  // output shifter loaded with the old value at the direction bit; the
  // shift brings in zeros, so the register ends in a zero tail
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      out_reg <= '0;
    else if (rise && en_reg && state_reg == DEV_DIR)
    begin
      if (is_power_ctrl(addr_reg))
        out_reg <= pwr_reg; // [R15] [R18]
      else
        out_reg <= '0;
    end
    else if (fall && state_reg == DEV_DATA)
      out_reg <= {out_reg[`PWR_CTRL_W-2:0], 1'b0}; // [R17]
  end

  // serial output changes only on falling edges, msb first
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      sdo_reg <= 1'b0;
    else if (fall)
    begin
      if (state_reg == DEV_DATA)
        sdo_reg <= out_reg[`PWR_CTRL_W-1]; // [R16] [R15]
      else
        sdo_reg <= 1'b0;
    end
  end

  assign link.from_device = sdo_reg;

  // power control register; the commit waits for the frame end so a
  // cut-short frame never leaves a half-shifted value behind
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      pwr_reg <= `PWR_CTRL_RESET; // [R1]
    else if (commit)
      pwr_reg <= data_reg; // [R20]
  end

  // 0 enables, 1 powers down (regulators) [R2]
  assign low_voltage_regulator_off = pwr_reg[`PWR_LOW_REG_BIT];
  assign clock_regulator_off = pwr_reg[`PWR_CLK_REG_BIT];
  assign converter_regulator_off = pwr_reg[`PWR_CONV_REG_BIT];
  assign bandgap_regulator_off = pwr_reg[`PWR_BGAP_REG_BIT];
  // common circuits and divided output clocks [R3]
  assign common_circuits_off = pwr_reg[`PWR_COMMON_BIT];
  assign output_clocks_off = pwr_reg[`PWR_OUTCLK_BIT];
  // loop clocks and test output access [R4]
  assign loop_clocks_off = pwr_reg[`PWR_LOOPCLK_BIT];
  assign test_out_b_blocked = pwr_reg[`PWR_TEST_B_BIT];
  assign test_out_a_blocked = pwr_reg[`PWR_TEST_A_BIT];
  // channel data inputs [R5]
  assign input_b_off = pwr_reg[`PWR_IN_B_BIT];
  assign input_a_off = pwr_reg[`PWR_IN_A_BIT];
  // converter channels; reference current set elsewhere [R6]
  assign converter_b_off = pwr_reg[`PWR_CONV_B_BIT];
  assign converter_a_off = pwr_reg[`PWR_CONV_A_BIT];

endmodule

// ==== dv/serial_link_properties.sv ====
// link-level checks on the four serial wires between host and device
// assumes: instanced beside the link interface; one ref_clk domain
`timescale 1ns/1ps

module serial_link_properties
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // link wires
  input wire logic frame_en,
  input wire logic shift_clk,
  input wire logic to_device,
  input wire logic from_device
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  property p_frame_open;
    $rose(frame_en) |-> !$past(shift_clk) && $past(shift_clk, 2);
  endproperty
  a_frame_open: assert property (p_frame_open)
    else $error("frame enable rose away from a shift clock fall");

  property p_frame_close;
    $fell(frame_en) |-> !$past(shift_clk) && $past(shift_clk, 2);
  endproperty
  a_frame_close: assert property (p_frame_close)
    else $error("frame enable fell away from a shift clock fall");

  property p_data_launch;
    $changed(to_device) |-> !$past(shift_clk) && $past(shift_clk, 2);
  endproperty
  a_data_launch: assert property (p_data_launch)
    else $error("serial input changed away from a shift clock fall");

  // the device answers one cycle after it sees the fall, two after the pin falls
  property p_reply_low_half;
    $changed(from_device) && frame_en |-> !shift_clk && !$past(shift_clk);
  endproperty
  a_reply_low_half: assert property (p_reply_low_half)
    else $error("serial output changed while shift clock high");

  property p_high_half;
    $rose(shift_clk) |-> shift_clk[*4] ##1 !shift_clk;
  endproperty
  a_high_half: assert property (p_high_half)
    else $error("shift clock high phase not four cycles");

  property p_steady_at_sample;
    shift_clk |-> $stable(frame_en) && $stable(to_device);
  endproperty
  a_steady_at_sample: assert property (p_steady_at_sample)
    else $error("host lines moved while shift clock high");

  // the first trailing clock period (8 cycles) needs the enable to stay down meanwhile
  property p_trailing_gap;
    $fell(frame_en) |-> !frame_en[*8];
  endproperty
  a_trailing_gap: assert property (p_trailing_gap)
    else $error("new frame too soon after frame end");

  property p_quiet_input;
    !frame_en |-> !to_device;
  endproperty
  a_quiet_input: assert property (p_quiet_input)
    else $error("serial input high outside a frame");
endmodule

// ==== dv/testbench.sv ====
// self-checking bench: host and device joined by the serial link
// assumes: hw/ on the include path; single 250 MHz ref_clk
`timescale 1ns/1ps
`include "serial_ctl_map.svh"

module testbench
  import serial_ctl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [`HOST_REG_AW-1:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  wire [`PWR_CTRL_W-1:0] pwr_seen;
  logic [31:0] model_pwr;
  logic [31:0] rng = 32'h33;
  logic [31:0] v;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2 ref_clk = ~ref_clk;

  serial_link_if link();

  serial_ctl_host u_serial_ctl_host (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));

  serial_ctl_device u_serial_ctl_device (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(link),
    .low_voltage_regulator_off(pwr_seen[0]),
    .clock_regulator_off(pwr_seen[1]),
    .converter_regulator_off(pwr_seen[2]),
    .bandgap_regulator_off(pwr_seen[3]),
    .common_circuits_off(pwr_seen[4]), .output_clocks_off(pwr_seen[5]),
    .loop_clocks_off(pwr_seen[6]), .test_out_b_blocked(pwr_seen[7]),
    .test_out_a_blocked(pwr_seen[8]), .input_b_off(pwr_seen[9]),
    .input_a_off(pwr_seen[10]), .converter_b_off(pwr_seen[11]),
    .converter_a_off(pwr_seen[12]));

  serial_link_properties u_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .frame_en(link.frame_en), .shift_clk(link.shift_clk),
    .to_device(link.to_device), .from_device(link.from_device));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data is only valid in the single cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // one serial frame; compares shifted-out bits and power outputs
  task automatic xfer(input logic [9:0] a, input logic w,
                      input logic [15:0] d, input int len);
    logic [31:0] st;
    logic [31:0] exp;
    int n;
    bit q[$];
    exp = 32'h0;
    // serial output model: register msb first, zeros once it runs dry
    for (int i = `PWR_CTRL_W - 1; i >= 0; i--)
      q.push_back(a == `PWR_CTRL_ADDR && model_pwr[i]);
    for (int i = 0; i < len; i++)
      exp = {exp[30:0], (q.size() > 0 ? q.pop_front() : 1'b0)};
    // addresses that fit in 7 bits go out as short frames
    wr(`HOST_ADDR_REG, (32'(a > 10'h7f) << `HOST_WIDE_BIT) | a);
    wr(`HOST_WDATA_REG, {16'h0, d});
    wr(`HOST_LEN_REG, len);
    wr(`HOST_CTRL_REG, {30'h0, w, 1'b1});
    st = 32'h0;
    n = 0;
    rd(`HOST_STATUS_REG, st);
    chk("busy after start", 32'h1, st[`STATUS_BUSY_BIT]);
    while (st[`STATUS_DONE_BIT] !== 1'b1 && n < 600)
    begin
      rd(`HOST_STATUS_REG, st);
      n++;
    end
    chk("frame done", 32'h1 << `STATUS_DONE_BIT, st);
    rd(`HOST_RDATA_REG, st);
    chk("shifted out", exp, st);
    if (w && a == `PWR_CTRL_ADDR && len >= 13)
      model_pwr = {19'h0, d[12:0]};
    chk("power outputs", model_pwr, pwr_seen);
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      test_done;
    end
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    model_pwr = 32'h1fc0;
    @(posedge ref_clk);
    #1;
    chk("reset value", model_pwr, pwr_seen);
    xfer(10'h1c3, 1'b0, 16'h0, 13);
    rd(`HOST_ADDR_REG, v);
    chk("addr readback", 32'h101c3, v);
    rd(`HOST_LEN_REG, v);
    chk("len readback", 32'hd, v);
    xfer(10'h1c3, 1'b0, 16'h0, 16);
    for (int i = 0; i < 13; i++)
      xfer(10'h1c3, 1'b1, 16'h1 << i, 13);
    repeat (4)
    begin
      rng = xs(rng);
      xfer(10'h1c3, 1'b1, {3'h0, rng[12:0]}, 16);
    end
    xfer(10'h1c3, 1'b1, 16'h0aaa, 12);
    xfer(10'h1c4, 1'b1, 16'h1555, 13);
    xfer(10'h1c4, 1'b0, 16'h0, 13);
    // short-address frame: nothing here answers it, power word untouched
    xfer(10'h011, 1'b1, 16'h00ff, 8);
    rd(`HOST_ADDR_REG, v);
    chk("short addr readback", 32'h11, v);
    xfer(10'h1c3, 1'b0, 16'h0, 13);
    rd(4'h9, v);
    chk("unmapped read", 32'h0, v);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    model_pwr = 32'h1fc0;
    @(posedge ref_clk);
    #1;
    chk("second reset", model_pwr, pwr_seen);
    xfer(10'h1c3, 1'b1, 16'h0180, 13);
    test_done;
  end
endmodule
